// File: design/ifa_top.v
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "ifa_map.vh"
// Functional notes
// [RULE1] Set interrupt flag raises processor interrupt when I2C interrupt enabled.
// [RULE2] Flag set on entry to every state except idle code F8h.
// [RULE3] While flag set, hold SCL low once low; stay released while high.
// [RULE4] Firmware clears the flag by writing zero; hardware never clears.
// [RULE5] Flag zero: no serial interrupt and no SCL stretching. irq still shows the flag-set event held in ists_reg until it is read.
// [RULE6] Interrupt reaches processor only with dedicated enable bit set. Code gates si_irq only; irq passes the flag-set event under imsk_reg bit 0.
// [RULE7] Acknowledge flag set: ack own address, and general call if enabled.
// [RULE8] Acknowledge flag set: ack data bytes as master or addressed receiver.
// [RULE9] Addressed transmitter enters C8h after last byte is sent.
// [RULE10] Clearing flag in C8h: go not-addressed, keep SDA released.
// [RULE11] In C8h firmware may set acknowledge flag for later addresses.
// [RULE12] Not addressed: ignore addresses, no acknowledge, no interrupt.
// [RULE13] Released from bus, still detect START, STOP and shift data.
// [RULE14] Address recognition resumes whenever acknowledge flag is set.
// [RULE15] Acknowledge flag set mid-address still recognises that address.
// [RULE16] Status F8h means no relevant state and no interrupt pending.
// [RULE17] Status code stays unchanged until firmware clears the flag.
// [RULE18] Acknowledge flag zero leaves SDA high in acknowledge clock.
module ifa_top (
	input wire sys_clk,
	input wire rst,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [`IFA_AW-1:0] s_axi_awaddr,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	output reg [1:0] s_axi_bresp,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	input wire [`IFA_AW-1:0] s_axi_araddr,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	input wire scl_in,
	output reg scl_out,
	output reg scl_oe_n,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe_n,
	output reg si_irq,
	output reg irq
);
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_RX = 3'h2;
	localparam ST_TX = 3'h3;
	localparam ST_DONE = 3'h4;
	localparam ST_MRX = 3'h5;

	// ==========================================================
	// Functions
	function is_map;
		input [`IFA_AW-1:0] a;
		begin
			is_map = (a == `IFA_OFF_CTRL) || (a == `IFA_OFF_STAT) ||
				(a == `IFA_OFF_OWN) || (a == `IFA_OFF_DATA) ||
				(a == `IFA_OFF_IEN) || (a == `IFA_OFF_ISTS) ||
				(a == `IFA_OFF_IMSK) || (a == `IFA_OFF_MODE);
		end
	endfunction

	function [7:0] rx_code;
		input gc;
		input ack;
		begin
			if (gc)
				rx_code = ack ? `IFA_ST_GC_ACK : `IFA_ST_GC_NACK;
			else
				rx_code = ack ? `IFA_ST_RX_ACK : `IFA_ST_RX_NACK;
		end
	endfunction

	// ==========================================================
	// Declarations
	wire [1:0] pin_s;
	wire [1:0] pin_p;
	wire scl_s = pin_s[1];
	wire sda_s = pin_s[0];
	wire scl_rise = scl_s & ~pin_p[1];
	wire scl_fall = ~scl_s & pin_p[1];
	wire bus_hi = scl_s & pin_p[1];
	wire start_det = bus_hi & pin_p[0] & ~sda_s;
	wire stop_det = bus_hi & ~pin_p[0] & sda_s;
	reg [`IFA_AW-1:0] aw_addr_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;
	reg [7:0] ctrl_reg;
	reg si_reg;
	reg [7:0] status_reg;
	reg [7:0] own_addr_reg;
	reg [7:0] tx_data_reg;
	reg [7:0] rx_data_reg;
	reg [7:0] ien_reg;
	reg [`IFA_EV_W-1:0] ists_reg;
	reg [`IFA_EV_W-1:0] imsk_reg;
	reg mode_reg;
	reg [2:0] state_reg;
	reg [3:0] cnt_reg;
	reg [7:0] sh_reg;
	reg [7:0] tx_sh_reg;
	reg [7:0] pend_reg;
	reg pend_ok_reg;
	reg sda_low_reg;
	reg gc_reg;
	reg last_reg;
	reg tx_addr_reg;
	reg ack_in_reg;
	reg ev_set;
	reg [7:0] ev_code;
	reg [31:0] rd_val;
	wire aa = ctrl_reg[`IFA_AA_BIT];
	wire wr_fire = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
	wire wr_lo = wr_fire & w_strb_reg[0];
	wire wr_ctrl = wr_lo & (aw_addr_reg == `IFA_OFF_CTRL);
	wire si_clr = wr_ctrl & ~w_data_reg[`IFA_SI_BIT]; // [RULE4]
	wire rd_fire = s_axi_arvalid & s_axi_arready;
	wire rd_ists = rd_fire & (s_axi_araddr == `IFA_OFF_ISTS);
	wire addressed = (state_reg == ST_RX) || (state_reg == ST_TX);
	wire [`IFA_EV_W-1:0] ev_vec = {stop_det, start_det, ev_set};

	// Pin synchroniser for SCL and SDA
	ifa_sync #(
		.W(2)
	) u_sync (
		.clk(sys_clk),
		.rst(rst),
		.d({scl_in, sda_in}),
		.q(pin_s),
		.q_prev(pin_p)
	);

	// ==========================================================
	// AXI4-Lite write channel
	always @(posedge sys_clk) begin
		if (rst) begin
			s_axi_awready <= 1'h1;
			s_axi_wready <= 1'h1;
			s_axi_bvalid <= 1'h0;
			s_axi_bresp <= `IFA_RESP_OK;
			aw_addr_reg <= {`IFA_AW{1'b0}};
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'h0;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'h0;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'h1;
				s_axi_bresp <= is_map(aw_addr_reg) ?
					`IFA_RESP_OK : `IFA_RESP_ERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'h0;
				s_axi_awready <= 1'h1;
				s_axi_wready <= 1'h1;
			end
		end
	end

	// Read data selection; unused bits read as zero
	always @* begin
		rd_val = 32'h00000000;
		case (s_axi_araddr)
		`IFA_OFF_CTRL: begin
			rd_val[7:0] = ctrl_reg;
			rd_val[`IFA_SI_BIT] = si_reg;
		end
		`IFA_OFF_STAT: rd_val[7:0] = status_reg;
		`IFA_OFF_OWN: rd_val[7:0] = own_addr_reg;
		`IFA_OFF_DATA: rd_val[7:0] = rx_data_reg;
		`IFA_OFF_IEN: rd_val[7:0] = ien_reg;
		`IFA_OFF_ISTS: rd_val[`IFA_EV_W-1:0] = ists_reg;
		`IFA_OFF_IMSK: rd_val[`IFA_EV_W-1:0] = imsk_reg;
		`IFA_OFF_MODE: rd_val[`IFA_MRX_BIT] = mode_reg;
		default: rd_val = 32'h00000000;
		endcase
	end

	// AXI4-Lite read channel
	always @(posedge sys_clk) begin
		if (rst) begin
			s_axi_arready <= 1'h1;
			s_axi_rvalid <= 1'h0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `IFA_RESP_OK;
		end else begin
			if (rd_fire) begin
				s_axi_arready <= 1'h0;
				s_axi_rvalid <= 1'h1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= is_map(s_axi_araddr) ?
					`IFA_RESP_OK : `IFA_RESP_ERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'h0;
				s_axi_arready <= 1'h1;
			end
		end
	end

	// ==========================================================
	// Software registers
	always @(posedge sys_clk) begin
		if (rst) begin
			ctrl_reg <= `IFA_RST_CTRL;
			own_addr_reg <= `IFA_RST_OWN;
			tx_data_reg <= 8'h00;
			ien_reg <= `IFA_RST_IEN;
			imsk_reg <= {`IFA_EV_W{1'b0}};
			mode_reg <= 1'h0;
		end else if (wr_lo) begin
			case (aw_addr_reg)
			`IFA_OFF_CTRL: ctrl_reg <= w_data_reg[7:0]; // [RULE11] [RULE14]
			`IFA_OFF_OWN: own_addr_reg <= w_data_reg[7:0];
			`IFA_OFF_DATA: tx_data_reg <= w_data_reg[7:0];
			`IFA_OFF_IEN: ien_reg <= w_data_reg[7:0];
			`IFA_OFF_IMSK: imsk_reg <= w_data_reg[`IFA_EV_W-1:0];
			`IFA_OFF_MODE: mode_reg <= w_data_reg[`IFA_MRX_BIT];
			default: mode_reg <= mode_reg;
			endcase
		end
	end

	// ==========================================================
	// Flag set events and the status code they carry
	always @* begin
		ev_set = 1'h0;
		ev_code = pend_reg;
		if ((start_det || stop_det) && addressed) begin
			ev_set = 1'h1;
			ev_code = `IFA_ST_STOP;
		end else if (scl_fall && cnt_reg == `IFA_CNT_END && pend_ok_reg) begin
			ev_set = 1'h1; // [RULE2]
			if (state_reg == ST_TX && !tx_addr_reg) begin
				if (!ack_in_reg)
					ev_code = `IFA_ST_TX_NACK;
				else if (last_reg)
					ev_code = `IFA_ST_TX_LAST; // [RULE9]
				else
					ev_code = `IFA_ST_TX_ACK;
			end
		end
	end

	// Interrupt flag and status; a set wins over a clear
	always @(posedge sys_clk) begin
		if (rst) begin
			si_reg <= 1'h0;
			status_reg <= `IFA_ST_IDLE; // [RULE16]
		end else if (ev_set) begin
			si_reg <= 1'h1;
			status_reg <= ev_code;
		end else if (si_clr) begin
			si_reg <= 1'h0; // [RULE4]
			status_reg <= `IFA_ST_IDLE; // [RULE16] [RULE17]
		end
	end

	// Sticky event bits cleared by reading them, and the outputs
	always @(posedge sys_clk) begin
		if (rst) begin
			ists_reg <= {`IFA_EV_W{1'b0}};
			irq <= 1'h0;
			si_irq <= 1'h0;
		end else begin
			ists_reg <= (rd_ists ? {`IFA_EV_W{1'b0}} : ists_reg) | ev_vec;
			irq <= |(ists_reg & imsk_reg);
			si_irq <= si_reg & ien_reg[`IFA_IEN_BIT]; // [RULE1] [RULE5] [RULE6]
		end
	end

	// SCL stretching: grab the line only once it is already low
	always @(posedge sys_clk) begin
		if (rst) begin
			scl_oe_n <= 1'h1;
			scl_out <= 1'h0;
			sda_out <= 1'h0;
			sda_oe_n <= 1'h1;
		end else begin
			if (!si_reg)
				scl_oe_n <= 1'h1; // [RULE5]
			else if (!scl_s)
				scl_oe_n <= 1'h0; // [RULE3]
			scl_out <= 1'h0;
			sda_out <= 1'h0;
			sda_oe_n <= ~sda_low_reg;
		end
	end

	// ==========================================================
	// Bus engine: shifts bits, decides acknowledges, tracks mode
	always @(posedge sys_clk) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 4'h0;
			sh_reg <= 8'h00;
			tx_sh_reg <= 8'h00;
			pend_reg <= `IFA_ST_IDLE;
			pend_ok_reg <= 1'h0;
			sda_low_reg <= 1'h0;
			gc_reg <= 1'h0;
			last_reg <= 1'h0;
			tx_addr_reg <= 1'h0;
			ack_in_reg <= 1'h0;
			rx_data_reg <= 8'h00;
		end else if (start_det) begin
			cnt_reg <= `IFA_CNT_PRE; // [RULE13] START's SCL fall wraps to 0
			sda_low_reg <= 1'h0;
			pend_ok_reg <= 1'h0;
			state_reg <= mode_reg ? ST_MRX : ST_ADDR;
		end else if (stop_det) begin
			cnt_reg <= 4'h0; // [RULE13]
			sda_low_reg <= 1'h0;
			pend_ok_reg <= 1'h0;
			state_reg <= ST_IDLE;
		end else begin
			if (scl_rise) begin
				if (cnt_reg < `IFA_CNT_END)
					sh_reg <= {sh_reg[6:0], sda_s}; // [RULE13]
				else
					ack_in_reg <= ~sda_s;
			end
			if (scl_fall) begin
				if (cnt_reg == `IFA_CNT_END)
					cnt_reg <= 4'h0;
				else
					cnt_reg <= cnt_reg + 4'h1;
				if (cnt_reg == `IFA_CNT_ACK) begin
					pend_ok_reg <= 1'h0;
					sda_low_reg <= 1'h0; // [RULE18]
					case (state_reg)
					ST_ADDR: begin
						// Flag sampled only at byte end
						if (aa && sh_reg[7:1] == own_addr_reg[7:1]) begin
							sda_low_reg <= 1'h1; // [RULE7] [RULE15]
							pend_ok_reg <= 1'h1;
							gc_reg <= 1'h0;
							tx_addr_reg <= sh_reg[0];
							pend_reg <= sh_reg[0] ?
								`IFA_ST_OWN_R : `IFA_ST_OWN_W;
							state_reg <= sh_reg[0] ? ST_TX : ST_RX;
						end else if (aa && own_addr_reg[`IFA_GC_BIT] &&
							sh_reg == `IFA_GC_ADDR) begin
							sda_low_reg <= 1'h1; // [RULE7] [RULE15]
							pend_ok_reg <= 1'h1;
							gc_reg <= 1'h1;
							pend_reg <= `IFA_ST_GC;
							state_reg <= ST_RX;
						end else begin
							state_reg <= ST_IDLE; // [RULE12]
						end
					end
					ST_RX: begin
						sda_low_reg <= aa; // [RULE8] [RULE18]
						pend_ok_reg <= 1'h1;
						rx_data_reg <= sh_reg;
						pend_reg <= rx_code(gc_reg, aa);
						if (!aa)
							state_reg <= ST_IDLE;
					end
					ST_MRX: begin
						sda_low_reg <= aa; // [RULE8] [RULE18]
						pend_ok_reg <= 1'h1;
						rx_data_reg <= sh_reg;
						pend_reg <= aa ? `IFA_ST_MRX_ACK : `IFA_ST_MRX_NACK;
					end
					ST_TX: pend_ok_reg <= 1'h1;
					default: pend_ok_reg <= 1'h0; // [RULE12]
					endcase
				end else if (cnt_reg == `IFA_CNT_END) begin
					sda_low_reg <= 1'h0;
					if (state_reg == ST_TX && !tx_addr_reg &&
						(!ack_in_reg || last_reg))
						state_reg <= ST_DONE; // [RULE9]
				end else if (state_reg == ST_TX) begin
					sda_low_reg <= ~tx_sh_reg[7];
					tx_sh_reg <= {tx_sh_reg[6:0], 1'h0};
				end
			end
			// Next byte goes out when firmware releases the flag
			if (si_clr && state_reg == ST_TX && !ev_set) begin
				sda_low_reg <= ~tx_data_reg[7];
				tx_sh_reg <= {tx_data_reg[6:0], 1'h0};
				last_reg <= ~w_data_reg[`IFA_AA_BIT]; // AA as written now
				tx_addr_reg <= 1'h0;
			end
			if (si_clr && state_reg == ST_DONE && !ev_set)
				state_reg <= ST_IDLE; // [RULE10]
		end
	end
endmodule // ifa_top

// File: common/ifa_map.vh
`ifndef IFA_MAP_VH
`define IFA_MAP_VH

// ==========================================================
// Register byte offsets (AXI4-Lite, one word each)
`define IFA_AW 8
`define IFA_OFF_CTRL 8'h00
`define IFA_OFF_STAT 8'h04
`define IFA_OFF_OWN 8'h08
`define IFA_OFF_DATA 8'h0C
`define IFA_OFF_IEN 8'h10
`define IFA_OFF_ISTS 8'h14
`define IFA_OFF_IMSK 8'h18
`define IFA_OFF_MODE 8'h1C

// ==========================================================
// Field positions
`define IFA_SI_BIT 3
`define IFA_AA_BIT 2
`define IFA_GC_BIT 0
`define IFA_IEN_BIT 4
`define IFA_MRX_BIT 0
`define IFA_EV_W 3
`define IFA_EV_SI 0
`define IFA_EV_START 1
`define IFA_EV_STOP 2

// ==========================================================
// Reset values
`define IFA_RST_CTRL 8'h00
`define IFA_RST_OWN 8'h00
`define IFA_RST_IEN 8'h00

// ==========================================================
// Status codes
`define IFA_ST_IDLE 8'hF8
`define IFA_ST_MRX_ACK 8'h50
`define IFA_ST_MRX_NACK 8'h58
`define IFA_ST_OWN_W 8'h60
`define IFA_ST_GC 8'h70
`define IFA_ST_RX_ACK 8'h80
`define IFA_ST_RX_NACK 8'h88
`define IFA_ST_GC_ACK 8'h90
`define IFA_ST_GC_NACK 8'h98
`define IFA_ST_STOP 8'hA0
`define IFA_ST_OWN_R 8'hA8
`define IFA_ST_TX_ACK 8'hB8
`define IFA_ST_TX_NACK 8'hC0
`define IFA_ST_TX_LAST 8'hC8

// ==========================================================
// Bit counter marks and bus answers
`define IFA_CNT_ACK 4'h7
`define IFA_CNT_END 4'h8
`define IFA_CNT_PRE 4'hF
`define IFA_GC_ADDR 8'h00
`define IFA_RESP_OK 2'h0
`define IFA_RESP_ERR 2'h2

`endif

// File: design/ifa_sync.v
`timescale 1ns/10ps
// ==========================================================
// Two-flop synchroniser with a third stage for edge finding
module ifa_sync #(
	parameter W = 2
) (
	input wire clk,
	input wire rst,
	input wire [W-1:0] d,
	output reg [W-1:0] q,
	output reg [W-1:0] q_prev
);
	reg [W-1:0] meta_reg;

	// First stage feeds only the second stage
	always @(posedge clk) begin
		if (rst) begin
			meta_reg <= {W{1'b1}};
			q <= {W{1'b1}};
			q_prev <= {W{1'b1}};
		end else begin
			meta_reg <= d;
			q <= meta_reg;
			q_prev <= q;
		end
	end
endmodule // ifa_sync

// File: verif/ifa_top_asserts.sv
`timescale 1ns/10ps
// ==========================================================
// Port checker for the flag and acknowledge block
module ifa_top_asserts (
	input wire sys_clk,
	input wire rst,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire scl_in,
	input wire scl_out,
	input wire scl_oe_n,
	input wire sda_out,
	input wire sda_oe_n,
	input wire si_irq
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// Line drivers
	a_stretch_low: assert property ($fell(scl_oe_n) |-> !$past(scl_in, 3))
		else $error("stretch began with SCL high");
	a_stretch_flag: assert property ($fell(scl_oe_n) |-> si_irq)
		else $error("stretch without interrupt");
	a_stretch_end: assert property ($fell(si_irq) |-> ##[0:2] scl_oe_n)
		else $error("stretch kept after flag clear");
	a_ack_low: assert property ($fell(sda_oe_n) |-> !$past(scl_in, 3))
		else $error("SDA driven while SCL high");
	a_drive_zero: assert property (!scl_oe_n || !sda_oe_n |-> !scl_out && !sda_out)
		else $error("driven line not low");
	// Register bus answers
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read not answered");
	a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write not answered");
	a_b_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("new write taken before response");
endmodule // ifa_top_asserts

bind ifa_top ifa_top_asserts ifa_top_asserts_i (.sys_clk, .rst, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .scl_in, .scl_out, .scl_oe_n, .sda_out,
	.sda_oe_n, .si_irq);

// File: verif/ifa_bus_master.sv
`timescale 1ns/10ps
// ==========================================================
// Bus master model, open drain with pull-ups outside
module ifa_bus_master (
	output reg scl_m,
	output reg sda_m,
	input wire scl,
	input wire sda,
	output reg err
);
	// Idle bus
	initial begin
		scl_m = 1;
		sda_m = 1;
		err = 0;
	end
	// One bit: low 240 ns, high 80 ns, waits out stretching
	task bit_x(input b, output s);
		integer n;
		#40 sda_m = b;
		#200 scl_m = 1;
		for (n = 0; n < 400 && !scl; n = n + 1)
			#40;
		if (!scl)
			err = 1;
		#80 s = sda;
		scl_m = 0;
	endtask
	// Start or repeated start
	task start_c;
		#40 sda_m = 1;
		#200 scl_m = 1;
		#160 sda_m = 0;
		#160 scl_m = 0;
	endtask
	// Stop
	task stop_c;
		#40 sda_m = 0;
		#200 scl_m = 1;
		#160 sda_m = 1;
		#160;
	endtask
	// Byte MSB first, then the acknowledge slot
	task xfer(input [7:0] d, input am, output [7:0] q, output a);
		integer i;
		for (i = 7; i >= 0; i = i - 1)
			bit_x(d[i], q[i]);
		bit_x(am, a);
	endtask
endmodule // ifa_bus_master

// File: verif/test_i2c_irq_flag_and_ack_control.sv
`timescale 1ns/10ps
`include "ifa_map.vh"
// ==========================================================
// Bench
module test_i2c_irq_flag_and_ack_control;
	reg sys_clk = 0;
	reg rst = 1;
	reg aw = 0, wv = 0, br = 0, ar = 0, rr = 0;
	reg [7:0] awa = 0, ara = 0, q;
	reg [31:0] wd = 0, rdv, lf = 32'h6246;
	reg [1:0] rsp;
	reg a;
	integer fails = 0, tests_run = 0, k;
	wire awr, wr, bv, arr, rv, sclo, scloe, sdao, sdaoe, si_irq, irq;
	wire scl_m, sda_m, err;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	// Open-drain lines with pull-ups
	wire scl = scl_m & (scloe | sclo);
	wire sda = sda_m & (sdaoe | sdao);

	ifa_top ifa_top_i (.sys_clk(sys_clk), .rst(rst), .s_axi_awvalid(aw),
		.s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
		.s_axi_arvalid(ar), .s_axi_arready(arr), .s_axi_araddr(ara),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .scl_in(scl), .scl_out(sclo), .scl_oe_n(scloe),
		.sda_in(sda), .sda_out(sdao), .sda_oe_n(sdaoe), .si_irq(si_irq),
		.irq(irq));
	ifa_bus_master ifa_bus_master_i (.scl_m(scl_m), .sda_m(sda_m), .scl(scl),
		.sda(sda), .err(err));

	// Clock
	always #20 sys_clk = ~sys_clk;

	// Expectations and random source
	function [31:0] nx(input [31:0] s);
		nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function [7:0] rx_code(input aa);
		rx_code = aa ? `IFA_ST_RX_ACK : `IFA_ST_RX_NACK;
	endfunction
	function [7:0] mrx_code(input aa);
		mrx_code = aa ? `IFA_ST_MRX_ACK : `IFA_ST_MRX_NACK;
	endfunction
	// Compare and count
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		tests_run = tests_run + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("CHECK FAILED %0s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// Verdict
	task tally_and_finish;
		if (fails == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// One register write or read
	task bus(input w, input [7:0] ad, input [31:0] dt);
		integer n;
		@(posedge sys_clk);
		aw <= w;
		wv <= w;
		br <= w;
		awa <= ad;
		wd <= dt;
		ar <= !w;
		rr <= !w;
		ara <= ad;
		for (n = 0; n < 50; n = n + 1) begin
			@(posedge sys_clk);
			if (awr)
				aw <= 0;
			if (wr)
				wv <= 0;
			if (arr)
				ar <= 0;
			if (br & bv | rr & rv) begin
				br <= 0;
				rr <= 0;
				rdv = rdata;
				rsp = w ? bresp : rresp;
				n = 99;
			end
		end
		if (n != 100) begin
			fails = fails + 1;
			tally_and_finish;
		end
	endtask
	task rd(input [7:0] ad, input [31:0] e, input string nm);
		bus(0, ad, 0);
		chk(nm, rdv, e);
	endtask
	// Bounded wait for the interrupt flag
	task wsi;
		integer n;
		for (n = 0; n < 300 && si_irq !== 1; n = n + 1)
			@(posedge sys_clk);
		chk("flag set", si_irq, 1);
		if (si_irq !== 1)
			tally_and_finish;
	endtask

	// Main sequence
	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 0;
		rd(`IFA_OFF_STAT, `IFA_ST_IDLE, "idle status");
		rd(8'h20, 0, "unmapped");
		chk("unmapped resp", rsp, `IFA_RESP_ERR);
		bus(1, 8'h20, 0);
		chk("unmapped wr resp", rsp, `IFA_RESP_ERR);
		bus(1, `IFA_OFF_OWN, 8'hA4);
		bus(1, `IFA_OFF_IEN, 8'h10);
		bus(1, `IFA_OFF_CTRL, 8'h04);
		ifa_bus_master_i.start_c;
		ifa_bus_master_i.xfer(8'hA4, 1, q, a);
		chk("addr ack", a, 0);
		wsi;
		chk("stretch", scloe, 0);
		rd(`IFA_OFF_STAT, `IFA_ST_OWN_W, "own write");
		// Data bytes with acknowledge flag set, then clear
		for (k = 0; k < 2; k = k + 1) begin
			bus(1, `IFA_OFF_CTRL, k ? 0 : 4);
			repeat (2) @(posedge sys_clk);
			chk("flag clear", si_irq, 0);
			chk("release", scloe, 1);
			lf = nx(lf);
			ifa_bus_master_i.xfer(lf[7:0], 1, q, a);
			chk("data ack", a, k);
			wsi;
			rd(`IFA_OFF_STAT, rx_code(!k), "rx status");
			rd(`IFA_OFF_DATA, lf[7:0], "rx data");
		end
		// Not addressed: monitor only
		bus(1, `IFA_OFF_CTRL, 0);
		ifa_bus_master_i.stop_c;
		bus(1, `IFA_OFF_IMSK, 2);
		bus(0, `IFA_OFF_ISTS, 0);
		ifa_bus_master_i.start_c;
		ifa_bus_master_i.xfer(8'hA4, 1, q, a);
		chk("not addressed", a, 1);
		repeat (8) @(posedge sys_clk);
		chk("no flag", si_irq, 0);
		chk("start irq", irq, 1);
		rd(`IFA_OFF_ISTS, 2, "start event");
		repeat (2) @(posedge sys_clk);
		chk("irq clear", irq, 0);
		// Slave transmitter, last byte
		bus(1, `IFA_OFF_OWN, 8'hA5);
		bus(1, `IFA_OFF_CTRL, 4);
		ifa_bus_master_i.start_c;
		ifa_bus_master_i.xfer(8'hA5, 1, q, a);
		chk("read addr ack", a, 0);
		wsi;
		rd(`IFA_OFF_STAT, `IFA_ST_OWN_R, "tx status");
		lf = nx(lf);
		bus(1, `IFA_OFF_DATA, lf[7:0]);
		bus(1, `IFA_OFF_CTRL, 0);
		ifa_bus_master_i.xfer(8'hFF, 0, q, a);
		chk("tx byte", q, lf[7:0]);
		wsi;
		rd(`IFA_OFF_STAT, `IFA_ST_TX_LAST, "last byte");
		bus(1, `IFA_OFF_CTRL, 4);
		repeat (2) @(posedge sys_clk);
		chk("sda free", sdaoe, 1);
		// Recognition back on: general call
		ifa_bus_master_i.stop_c;
		ifa_bus_master_i.start_c;
		ifa_bus_master_i.xfer(`IFA_GC_ADDR, 1, q, a);
		chk("gc ack", a, 0);
		wsi;
		rd(`IFA_OFF_STAT, `IFA_ST_GC, "gc status");
		// STOP while addressed raises the flag again
		bus(1, `IFA_OFF_CTRL, 4);
		ifa_bus_master_i.stop_c;
		wsi;
		rd(`IFA_OFF_STAT, `IFA_ST_STOP, "stop status");
		// Master receiver: every byte after START is data
		bus(1, `IFA_OFF_MODE, 1);
		bus(1, `IFA_OFF_CTRL, 4);
		ifa_bus_master_i.start_c;
		for (k = 0; k < 2; k = k + 1) begin
			lf = nx(lf);
			ifa_bus_master_i.xfer(lf[7:0], 1, q, a);
			chk("mrx ack", a, k);
			wsi;
			rd(`IFA_OFF_STAT, mrx_code(!k), "mrx status");
			rd(`IFA_OFF_DATA, lf[7:0], "mrx data");
			bus(1, `IFA_OFF_CTRL, 0);
		end
		// Acknowledge flag set while the address is still arriving
		bus(1, `IFA_OFF_MODE, 0);
		ifa_bus_master_i.stop_c;
		ifa_bus_master_i.start_c;
		fork
			ifa_bus_master_i.xfer(8'hA4, 1, q, a);
			begin
				repeat (30) @(posedge sys_clk);
				bus(1, `IFA_OFF_CTRL, 4);
			end
		join
		chk("late aa ack", a, 0);
		wsi;
		rd(`IFA_OFF_STAT, `IFA_ST_OWN_W, "late aa status");
		chk("bus stall", err, 0);
		tally_and_finish;
	end
endmodule // test_i2c_irq_flag_and_ack_control
